/* File: logic/ctg_pkg.sv */
// Package for the channel trigger gate generator: register map, mode codes, constants
// ============================================================
// ============================================================
package ctg_pkg;
  // Register indices; the byte address is the index times four
  localparam logic [15:0] CTG_IDX_MODE    = 16'h9EA2;
  localparam logic [15:0] CTG_IDX_PRIMARY = 16'hA4D8;
  localparam logic [15:0] CTG_IDX_SECOND  = 16'hA53C;
  localparam logic [15:0] CTG_IDX_ORMASK  = 16'h9E8C;
  localparam logic [15:0] CTG_IDX_STATUS  = 16'h9E8D;
  localparam logic [17:0] CTG_ADDR_MODE    = {CTG_IDX_MODE,    2'b00};
  localparam logic [17:0] CTG_ADDR_PRIMARY = {CTG_IDX_PRIMARY, 2'b00};
  localparam logic [17:0] CTG_ADDR_SECOND  = {CTG_IDX_SECOND,  2'b00};
  localparam logic [17:0] CTG_ADDR_ORMASK  = {CTG_IDX_ORMASK,  2'b00};
  localparam logic [17:0] CTG_ADDR_STATUS  = {CTG_IDX_STATUS,  2'b00};
  localparam int          CTG_ADDR_W       = 18;
  // Mode codes and flags
  localparam logic [31:0] CTG_RISING_EDGE_CODE    = 32'h0000_0001;
  localparam logic [31:0] CTG_FALLING_EDGE_CODE   = 32'h0000_0002;
  localparam logic [31:0] CTG_WINDOW_ENTER_CODE   = 32'h0000_0020;
  localparam logic [31:0] CTG_WINDOW_LEAVE_CODE   = 32'h0000_0040;
  localparam logic [31:0] CTG_INSIDE_WINDOW_CODE  = 32'h0000_0080;
  localparam logic [31:0] CTG_OUTSIDE_WINDOW_CODE = 32'h0000_0100;
  localparam logic [31:0] CTG_REARM_FLAG          = 32'h0100_0000;
  localparam logic [31:0] CTG_HYSTERESIS_FLAG     = 32'h0200_0000;
  localparam logic [31:0] CTG_FIRST_CHANNEL_MASK_BIT = 32'h0000_0001;
  // Reset values
  localparam logic [31:0] CTG_RESET_WORD = 32'h0000_0000;
  // Status bit positions
  localparam int CTG_ST_GATE  = 0;
  localparam int CTG_ST_ARMED = 1;
  localparam int CTG_ST_VALID = 2;
  // AHB encodings
  localparam logic [1:0] CTG_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] CTG_HSIZE_WORD    = 3'b010;
  // Decoded mode
  typedef enum logic [2:0] {
    CTG_M_OFF    = 3'h0,
    CTG_M_POS    = 3'h1,
    CTG_M_NEG    = 3'h2,
    CTG_M_WENTER = 3'h3,
    CTG_M_WLEAVE = 3'h4,
    CTG_M_INWIN  = 3'h5,
    CTG_M_OUTWIN = 3'h6,
    CTG_M_POSHYS = 3'h7
  } ctg_mode_e;
endpackage

/* File: logic/ctg_channel_trigger_gate_generator.sv */
// Channel trigger gate generator with AHB-Lite register slave
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ctg_channel_trigger_gate_generator
  import ctg_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] sample_data,
  output logic                     gate,
  output logic                     armed
);

  // ============================================================
  // State
  typedef struct packed {
    logic [31:0]                 mode;
    logic [31:0]                 primary_level;
    logic [31:0]                 secondary_level;
    logic [31:0]                 or_mask;
    logic                        wr_pend;
    logic [CTG_ADDR_W-1:0]       wr_addr;
    logic [31:0]                 rdata;
    logic                        prev_ok;
    logic signed [SAMPLE_W-1:0]  prev;
    logic                        gate;
    logic                        armed;
    logic                        ready;
    logic                        resp;
  } ctg_state_s;

  ctg_state_s s_q;
  ctg_state_s s_d;

  // ============================================================
  // Mode decode
  function automatic ctg_mode_e ctg_decode(input logic [31:0] m);
    ctg_mode_e r;
    r = CTG_M_OFF;
    if (m == CTG_RISING_EDGE_CODE || m == (CTG_RISING_EDGE_CODE | CTG_REARM_FLAG)) begin
      r = CTG_M_POS;
    end else if (m == CTG_FALLING_EDGE_CODE
                 || m == (CTG_FALLING_EDGE_CODE | CTG_REARM_FLAG)) begin
      r = CTG_M_NEG;
    end else if (m == (CTG_RISING_EDGE_CODE | CTG_HYSTERESIS_FLAG)) begin
      r = CTG_M_POSHYS;
    end else if (m == CTG_WINDOW_ENTER_CODE) begin
      r = CTG_M_WENTER;
    end else if (m == CTG_WINDOW_LEAVE_CODE) begin
      r = CTG_M_WLEAVE;
    end else if (m == CTG_INSIDE_WINDOW_CODE) begin
      r = CTG_M_INWIN;
    end else if (m == CTG_OUTSIDE_WINDOW_CODE) begin
      r = CTG_M_OUTWIN;
    end
    return r;
  endfunction

  // ============================================================
  // Level crossing helpers
  // Upward crossing of a level between two samples
  function automatic logic ctg_up(input logic signed [SAMPLE_W-1:0] p,
                                  input logic signed [SAMPLE_W-1:0] c,
                                  input logic signed [SAMPLE_W-1:0] l);
    return (p < l) && (c >= l);
  endfunction

  // Downward crossing of a level between two samples
  function automatic logic ctg_dn(input logic signed [SAMPLE_W-1:0] p,
                                  input logic signed [SAMPLE_W-1:0] c,
                                  input logic signed [SAMPLE_W-1:0] l);
    return (p >= l) && (c < l);
  endfunction

  // Window test, both bounds inclusive
  function automatic logic ctg_in(input logic signed [SAMPLE_W-1:0] v,
                                  input logic signed [SAMPLE_W-1:0] hi,
                                  input logic signed [SAMPLE_W-1:0] lo);
    return (v >= lo) && (v <= hi);
  endfunction

  // ============================================================
  // Register select
  typedef enum logic [2:0] {
    CTG_R_NONE    = 3'h0,
    CTG_R_MODE    = 3'h1,
    CTG_R_PRIMARY = 3'h3,
    CTG_R_SECOND  = 3'h2,
    CTG_R_ORMASK  = 3'h6,
    CTG_R_STATUS  = 3'h7
  } ctg_reg_e;

  // Maps a decoded bus address onto one register
  function automatic ctg_reg_e ctg_sel(input logic [CTG_ADDR_W-1:0] a);
    ctg_reg_e r;
    r = CTG_R_NONE;
    if (a == CTG_ADDR_MODE) begin
      r = CTG_R_MODE;
    end else if (a == CTG_ADDR_PRIMARY) begin
      r = CTG_R_PRIMARY;
    end else if (a == CTG_ADDR_SECOND) begin
      r = CTG_R_SECOND;
    end else if (a == CTG_ADDR_ORMASK) begin
      r = CTG_R_ORMASK;
    end else if (a == CTG_ADDR_STATUS) begin
      r = CTG_R_STATUS;
    end
    return r;
  endfunction

  // ============================================================
  // Register read path
  // Status word: gate, armed and history valid bits
  function automatic logic [31:0] ctg_status(input logic g,
                                             input logic a,
                                             input logic v);
    logic [31:0] w;
    w               = CTG_RESET_WORD;
    w[CTG_ST_GATE]  = g;
    w[CTG_ST_ARMED] = a;
    w[CTG_ST_VALID] = v;
    return w;
  endfunction

  // Read word of one register
  function automatic logic [31:0] ctg_rd_word(input ctg_reg_e   r,
                                              input ctg_state_s st);
    logic [31:0] w;
    w = CTG_RESET_WORD;
    unique case (r)
      CTG_R_MODE:    w = st.mode;
      CTG_R_PRIMARY: w = st.primary_level;
      CTG_R_SECOND:  w = st.secondary_level;
      CTG_R_ORMASK:  w = st.or_mask;
      CTG_R_STATUS:  w = ctg_status(st.gate, st.armed, st.prev_ok);
      default:       w = CTG_RESET_WORD;
    endcase
    return w;
  endfunction

  // ============================================================
  // Decoded controls and level roles
  logic                       addr_ok;
  logic                       wr_mode;
  logic                       rearm_on;
  logic                       chan_on;
  logic signed [SAMPLE_W-1:0] lvl_a;
  logic signed [SAMPLE_W-1:0] lvl_b;
  ctg_mode_e                  md;
  ctg_reg_e                   wr_sel;
  ctg_reg_e                   rd_sel;
  logic                       up_trig;
  logic                       dn_trig;
  logic                       up_aux;
  logic                       dn_aux;
  logic                       in_prev;
  logic                       in_cur;

  always_comb begin
    addr_ok  = hsel && hready && (htrans == CTG_HTRANS_NONSEQ) && (hsize == CTG_HSIZE_WORD);
    md       = ctg_decode(s_q.mode);
    rearm_on = (s_q.mode & CTG_REARM_FLAG) != CTG_RESET_WORD;
    chan_on  = (s_q.or_mask & CTG_FIRST_CHANNEL_MASK_BIT) != CTG_RESET_WORD;
    lvl_a    = s_q.primary_level[SAMPLE_W-1:0];
    lvl_b    = s_q.secondary_level[SAMPLE_W-1:0];
    wr_mode  = s_q.wr_pend && (s_q.wr_addr == CTG_ADDR_MODE);
    wr_sel   = ctg_sel(s_q.wr_addr);
    rd_sel   = ctg_sel(haddr[CTG_ADDR_W-1:0]);
  end

  // ============================================================
  // Crossings of the current sample against both levels
  always_comb begin
    up_trig = ctg_up(s_q.prev, sample_data, lvl_a);
    dn_trig = ctg_dn(s_q.prev, sample_data, lvl_a);
    up_aux  = ctg_up(s_q.prev, sample_data, lvl_b);
    dn_aux  = ctg_dn(s_q.prev, sample_data, lvl_b);
    in_prev = ctg_in(s_q.prev, lvl_a, lvl_b);
    in_cur  = ctg_in(sample_data, lvl_a, lvl_b);
  end

  // ============================================================
  // Edge re-arm steps, rising and falling
  logic                       pos_gate;
  logic                       pos_armed;
  logic                       neg_gate;
  logic                       neg_armed;

  always_comb begin
    pos_gate  = s_q.gate;
    pos_armed = s_q.armed;
    if (rearm_on && up_aux) begin
      pos_armed = 1'b1;
    end
    if (up_trig && (!rearm_on || s_q.armed)) begin
      pos_gate  = 1'b1;
      pos_armed = 1'b0;
    end else if (dn_trig) begin
      pos_gate  = 1'b0;
    end
    neg_gate  = s_q.gate;
    neg_armed = s_q.armed;
    if (rearm_on && dn_aux) begin
      neg_armed = 1'b1;
    end
    if (dn_trig && (!rearm_on || s_q.armed)) begin
      neg_gate  = 1'b1;
      neg_armed = 1'b0;
    end else if (up_trig) begin
      neg_gate  = 1'b0;
    end
  end

  // ============================================================
  // Hysteresis step
  logic                       hys_gate;

  always_comb begin
    hys_gate = s_q.gate;
    if (up_trig) begin
      hys_gate = 1'b1;
    end else if (dn_aux) begin
      hys_gate = 1'b0;
    end
  end

  // ============================================================
  // Window steps
  logic                       went_gate;
  logic                       wlev_gate;
  logic                       inw_gate;
  logic                       outw_gate;

  always_comb begin
    went_gate = s_q.gate;
    if (!in_prev && in_cur) begin
      went_gate = 1'b1;
    end else if (!in_cur) begin
      went_gate = 1'b0;
    end
    wlev_gate = s_q.gate;
    if (in_prev && !in_cur) begin
      wlev_gate = 1'b1;
    end else if (in_cur) begin
      wlev_gate = 1'b0;
    end
    inw_gate  = in_cur;
    outw_gate = !in_cur;
  end

  // ============================================================
  // Mode select of the engine step
  logic                       eng_gate;
  logic                       eng_armed;

  always_comb begin
    eng_gate  = s_q.gate;
    eng_armed = s_q.armed;
    if (!chan_on) begin
      eng_gate  = 1'b0;
      eng_armed = 1'b0;
    end else begin
      unique case (md)
        CTG_M_POS: begin
          if (s_q.prev_ok) begin
            eng_gate  = pos_gate;
            eng_armed = pos_armed;
          end
        end
        CTG_M_NEG: begin
          if (s_q.prev_ok) begin
            eng_gate  = neg_gate;
            eng_armed = neg_armed;
          end
        end
        CTG_M_POSHYS: begin
          if (s_q.prev_ok) begin
            eng_gate = hys_gate;
          end
        end
        CTG_M_WENTER: begin
          if (s_q.prev_ok) begin
            eng_gate = went_gate;
          end
        end
        CTG_M_WLEAVE: begin
          if (s_q.prev_ok) begin
            eng_gate = wlev_gate;
          end
        end
        CTG_M_INWIN:  eng_gate = inw_gate;
        CTG_M_OUTWIN: eng_gate = outw_gate;
        CTG_M_OFF: begin
          eng_gate  = 1'b0;
          eng_armed = 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // Next state
  always_comb begin
    s_d       = s_q;
    s_d.ready = 1'b1;
    s_d.resp  = 1'b0;

    // Data phase of a pending write
    if (s_q.wr_pend) begin
      unique case (wr_sel)
        CTG_R_MODE:    s_d.mode            = hwdata;
        CTG_R_PRIMARY: s_d.primary_level   = hwdata;
        CTG_R_SECOND:  s_d.secondary_level = hwdata;
        CTG_R_ORMASK:  s_d.or_mask         = hwdata;
        default:       s_d.or_mask         = s_q.or_mask;
      endcase
    end
    s_d.wr_pend = 1'b0;
    s_d.rdata   = CTG_RESET_WORD;

    // Address phase
    if (addr_ok) begin
      if (hwrite) begin
        s_d.wr_pend = 1'b1;
        s_d.wr_addr = haddr[CTG_ADDR_W-1:0];
      end else begin
        s_d.rdata = ctg_rd_word(rd_sel, s_q);
      end
    end

    // Trigger engine, one step per sample
    if (wr_mode) begin
      s_d.gate    = 1'b0;
      s_d.armed   = 1'b0;
      s_d.prev_ok = 1'b0;
    end else if (sample_valid) begin
      s_d.prev    = sample_data;
      s_d.prev_ok = 1'b1;
      s_d.gate    = eng_gate;
      s_d.armed   = eng_armed;
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    hrdata    = s_q.rdata;
    hreadyout = s_q.ready;
    hresp     = s_q.resp;
    gate      = s_q.gate;
    armed     = s_q.armed;
  end

endmodule

/* File: verif/ctg_sample_src.sv */
// Sample stream source standing in for the digitized channel
`timescale 1ns/1ps
module ctg_sample_src
  import ctg_pkg::*;
(
  input  wire logic          hclk,
  output logic               sample_valid,
  output logic signed [15:0] sample_data
);
  initial begin
    sample_valid = 1'b0;
    sample_data  = 16'h0000;
  end
  // One strobed sample, data scrambled once the strobe drops
  task automatic send(input logic signed [15:0] v);
    @(posedge hclk);
    sample_valid <= 1'b1;
    sample_data  <= v;
    @(posedge hclk);
    sample_valid <= 1'b0;
    sample_data  <= ~v;
  endtask
endmodule

/* File: verif/ctg_sva.sv */
// Checker of bus answers and gate timing at the block ports
`timescale 1ns/1ps
module ctg_sva
  import ctg_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sample_valid,
  input wire logic        gate,
  input wire logic        armed
);
  logic taken;
  logic wr_q;
  logic rd_q;
  logic wm_q;
  assign taken = hsel && hready && htrans == CTG_HTRANS_NONSEQ && hsize == CTG_HSIZE_WORD;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      wm_q <= 1'b0;
    end else begin
      wr_q <= taken && hwrite;
      rd_q <= taken && !hwrite;
      wm_q <= taken && hwrite && haddr[17:0] == CTG_ADDR_MODE;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_gate_cause: assert property (!$stable(gate) |-> $past(sample_valid) || $past(wr_q))
    else $error("gate moved without cause");
  a_armed_cause: assert property (!$stable(armed) |-> $past(sample_valid) || $past(wr_q))
    else $error("armed moved without cause");
  a_disarm_cause: assert property ($fell(armed) |-> gate || $past(wr_q))
    else $error("disarm without start");
  a_arm_no_start: assert property ($rose(armed) |-> !$rose(gate))
    else $error("start on arming sample");
  a_write_clears: assert property (wm_q |=> !gate && !armed)
    else $error("mode write kept gate");
  a_reset_quiet: assert property ($rose(hresetn) |-> !gate && !armed)
    else $error("gate set after reset");
  a_rdata_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  c_gate_start: cover property ($rose(gate));
  c_armed: cover property ($rose(armed));
  c_mode_write: cover property (wm_q ##1 !gate);
endmodule
bind ctg_channel_trigger_gate_generator ctg_sva i_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .sample_valid, .gate, .armed);

/* File: verif/ctg_channel_trigger_gate_generator_tb.sv */
// Testbench of register access and trigger mode sequences
`timescale 1ns/1ps
module ctg_channel_trigger_gate_generator_tb;
  import ctg_pkg::*;
  logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic               sample_valid, gate, armed;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic signed [15:0] sample_data;
  int                 n_mismatch = 0, num_checks = 0, cyc = 0;
  ctg_channel_trigger_gate_generator #(.SAMPLE_W(16)) i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .sample_valid, .sample_data, .gate, .armed);
  ctg_sample_src i_src (.hclk, .sample_valid, .sample_data);
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single word transfer, read data kept in rd
  task automatic bus(input logic [17:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, a};
    htrans <= CTG_HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= CTG_HSIZE_WORD;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge hclk);
      rd = hrdata;
    end while (hreadyout !== 1'b1);
    @(posedge hclk);
  endtask
  task automatic cfg(input logic [31:0] m, input logic [31:0] p, input logic [31:0] s);
    bus(CTG_ADDR_PRIMARY, 1'b1, p);
    bus(CTG_ADDR_SECOND, 1'b1, s);
    bus(CTG_ADDR_MODE, 1'b1, m);
  endtask
  task automatic smp(input int v, input logic g, input logic a);
    i_src.send(v[15:0]);
    @(negedge hclk);
    chk({30'h0, gate, armed}, {30'h0, g, a});
  endtask
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = CTG_HSIZE_WORD;
    hwdata  = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(CTG_ADDR_MODE, 1'b0, 32'h0);
    chk(rd, CTG_RESET_WORD);
    bus(18'h00010, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(CTG_ADDR_ORMASK, 1'b1, CTG_FIRST_CHANNEL_MASK_BIT);
    cfg(CTG_RISING_EDGE_CODE | CTG_REARM_FLAG, 100, 50);
    bus(CTG_ADDR_MODE, 1'b0, 32'h0);
    chk(rd, 32'h0100_0001);
    bus(CTG_ADDR_PRIMARY, 1'b0, 32'h0);
    chk(rd, 32'h0000_0064);
    smp(0, 0, 0);
    smp(60, 0, 1);
    bus(CTG_ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, (32'h1 << CTG_ST_ARMED) | (32'h1 << CTG_ST_VALID));
    smp(150, 1, 0);
    smp(90, 0, 0);
    smp(150, 0, 0);
    smp(40, 0, 0);
    smp(60, 0, 1);
    smp(150, 1, 0);
    bus(CTG_ADDR_MODE, 1'b1, CTG_RISING_EDGE_CODE | CTG_REARM_FLAG);
    smp(200, 0, 0);
    cfg(CTG_FALLING_EDGE_CODE | CTG_REARM_FLAG, -100, -50);
    smp(0, 0, 0);
    smp(-60, 0, 1);
    smp(-150, 1, 0);
    smp(-90, 0, 0);
    smp(-150, 0, 0);
    cfg(CTG_WINDOW_ENTER_CODE, 100, -100);
    smp(200, 0, 0);
    smp(0, 1, 0);
    smp(200, 0, 0);
    cfg(CTG_WINDOW_LEAVE_CODE, 100, -100);
    smp(0, 0, 0);
    smp(-200, 1, 0);
    smp(0, 0, 0);
    cfg(CTG_INSIDE_WINDOW_CODE, 100, -100);
    smp(0, 1, 0);
    smp(200, 0, 0);
    cfg(CTG_OUTSIDE_WINDOW_CODE, 100, -100);
    smp(-200, 1, 0);
    smp(100, 0, 0);
    cfg(CTG_RISING_EDGE_CODE | CTG_HYSTERESIS_FLAG, 100, 50);
    smp(200, 0, 0);
    smp(0, 0, 0);
    smp(150, 1, 0);
    smp(80, 1, 0);
    smp(40, 0, 0);
    cfg(CTG_RISING_EDGE_CODE, 100, 0);
    smp(0, 0, 0);
    smp(150, 1, 0);
    smp(50, 0, 0);
    smp(150, 1, 0);
    cfg(CTG_FALLING_EDGE_CODE, 100, 0);
    smp(150, 0, 0);
    smp(50, 1, 0);
    smp(150, 0, 0);
    smp(50, 1, 0);
    bus(CTG_ADDR_ORMASK, 1'b1, 32'h0);
    smp(50, 0, 0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(CTG_ADDR_MODE, 1'b0, 32'h0);
    chk(rd, CTG_RESET_WORD);
    give_verdict();
  end
endmodule
